// [rtl/uv_oc_pkg.sv]
package uv_oc_pkg;

    // ==========================================================
    // pages and command codes
    localparam int          NUM_PAGES        = 2;
    localparam logic [7:0]  CMD_UV_THRESHOLD = 8'h44;
    localparam logic [7:0]  CMD_UV_RESPONSE  = 8'h45;
    localparam logic [7:0]  CMD_OC_THRESHOLD = 8'h46;
    localparam logic [7:0]  CMD_OC_RESPONSE  = 8'h47;
    localparam logic [7:0]  CMD_FAULT_STATUS = 8'h7a;

    // ==========================================================
    // reset values
    localparam logic [15:0] UV_THR_RST       = 16'h0000;
    localparam logic [7:0]  UV_RESP_RST      = 8'h84;
    localparam logic [15:0] OC_THR_RST       = 16'h012c;
    localparam logic [7:0]  OC_RESP_RST      = 8'hc4;
    localparam logic [1:0]  STATUS_RST       = 2'h0;

    // ==========================================================
    // response byte fields and codes
    localparam int          MODE_HI          = 7;
    localparam int          MODE_LO          = 6;
    localparam int          RETRY_HI         = 5;
    localparam int          RETRY_LO         = 3;
    localparam int          DELAY_HI         = 2;
    localparam int          DELAY_LO         = 0;
    localparam logic [1:0]  UV_MODE_DISABLE  = 2'h2;
    localparam logic [1:0]  OC_MODE_DISABLE  = 2'h3;
    localparam logic [2:0]  RETRY_FOREVER    = 3'h7;
    localparam int          STATUS_UV_BIT    = 0;
    localparam int          STATUS_OC_BIT    = 1;

    // ==========================================================
    // timing
    localparam int unsigned CLK_FREQ_KHZ     = 200_000;
    localparam int unsigned RETRY_STEP_MS    = 25;
    localparam int unsigned RETRY_STEP_CYCLES = RETRY_STEP_MS * CLK_FREQ_KHZ;

    typedef enum logic [1:0] {
        st_off,
        st_on,
        st_latched,
        st_wait
    } rail_state_t;

endpackage

// [rtl/rail_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rail_if;
    logic [7:0]  uv_resp;
    logic [7:0]  oc_resp;
    logic [15:0] uv_thr;
    logic [15:0] oc_thr;
    logic        enabled;
    logic        ramping;
    logic        other_shutdown;
    logic [15:0] vout_mv;
    logic [15:0] iout_da;
    logic        out_en;
    logic        uv_event;
    logic        oc_event;

    modport ctrl (output uv_resp, oc_resp, uv_thr, oc_thr, enabled, ramping, other_shutdown,
                  vout_mv, iout_da, input out_en, uv_event, oc_event);
    modport responder (input uv_resp, oc_resp, uv_thr, oc_thr, enabled, ramping, other_shutdown,
                       vout_mv, iout_da, output out_en, uv_event, oc_event);
endinterface
`default_nettype wire

// [rtl/rail_responder.sv]
`timescale 1ns/1ps
`default_nettype none
module rail_responder
    import uv_oc_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = RETRY_STEP_CYCLES
) (
    input wire logic clock,        // 200 MHz
    input wire logic rst_b,        // async reset, active low
    rail_if.responder  rif         // config in, fault events out
);
    rail_state_t state_r;
    rail_state_t state_nxt;
    logic [31:0] wait_r;
    logic [31:0] wait_nxt;

    // ==========================================================
    // fault detection
    wire rail_on   = (state_r == st_on);
    wire uv_detect = rail_on && !rif.ramping && (rif.vout_mv < rif.uv_thr);
    wire oc_detect = rif.iout_da > rif.oc_thr;
    wire uv_shut   = uv_detect && (rif.uv_resp[MODE_HI:MODE_LO] == UV_MODE_DISABLE);
    wire oc_shut   = rail_on && oc_detect
                     && (rif.oc_resp[MODE_HI:MODE_LO] == OC_MODE_DISABLE);
    // undervoltage wins the retry policy when both trip together
    wire [7:0] trip_resp = uv_shut ? rif.uv_resp : rif.oc_resp;
    wire retry_on  = (trip_resp[RETRY_HI:RETRY_LO] == RETRY_FOREVER);
    wire [31:0] retry_cycles = 32'(trip_resp[DELAY_HI:DELAY_LO]) * STEP_CYCLES;

    assign rif.uv_event = uv_detect;
    assign rif.oc_event = oc_detect;
    assign rif.out_en   = rail_on;

    // ==========================================================
    // shutdown and retry sequencing
    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        case (state_r)
            st_off: begin
                if (rif.enabled) begin
                    state_nxt = st_on;
                end
            end
            st_on: begin
                if (!rif.enabled) begin
                    state_nxt = st_off;
                end else if (uv_shut || oc_shut) begin
                    state_nxt = retry_on ? st_wait : st_latched;
                    wait_nxt  = retry_cycles;
                end
            end
            st_latched: begin
                // only a restart of the rail leaves the latch
                if (!rif.enabled) begin
                    state_nxt = st_off;
                end
            end
            st_wait: begin
                if (!rif.enabled) begin
                    state_nxt = st_off;
                end else if (rif.other_shutdown) begin
                    state_nxt = st_latched;
                end else if (wait_r == 32'h0) begin
                    state_nxt = st_on;
                end else begin
                    wait_nxt = wait_r - 32'h1;
                end
            end
            default: begin
                state_nxt = st_off;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= st_off;
            wait_r  <= 32'h0;
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
        end
    end
endmodule // rail_responder
`default_nettype wire

// [rtl/uv_fault_response_oc_limit.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - undervoltage detection is masked while the output ramps or is off.
// - undervoltage response bits 7:6 select behaviour; 00 continues, 01 and 11 unsupported.
// - undervoltage response 10, or overcurrent response 11, shuts the output off then follows retry bits 5:3.
// - an undervoltage fault pulls the alert line low and sets its flag.
// - retry code 000 keeps output off until the rail restarts.
// - retry code 111 retries forever until commanded off, bias lost, other fault.
// - undervoltage response register resets to 84h, latch off without retry.
// - undervoltage response is a one-byte read-write register.
// - overcurrent threshold is 16-bit unsigned, 0.1 A per step.
// - overcurrent threshold resets to 12Ch, thirty amperes.
// - undervoltage compares output voltage against a 1 mV threshold register.
// - overcurrent action is set by the response register at 47h.
module uv_fault_response_oc_limit
    import uv_oc_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = RETRY_STEP_CYCLES
) (
    input  wire logic                  clock,             // 200 MHz
    input  wire logic                  rst_b,             // async reset, active low
    input  wire logic                  cmd_valid,         // command strobe, one cycle
    input  wire logic                  cmd_write,         // 1 write, 0 read
    input  wire logic                  cmd_page,          // selected rail
    input  wire logic [7:0]            cmd_code,          // command code
    input  wire logic [15:0]           cmd_wdata,         // write data
    output logic                       cmd_ack,           // accepted, one cycle
    output logic                       cmd_nak,           // unknown code, one cycle
    output logic      [15:0]           cmd_rdata,         // read data
    input  wire logic [NUM_PAGES-1:0]  ctrl_pin,          // rail enable pins, async
    input  wire logic                  bias_ok_pin,       // bias good, async
    input  wire logic [NUM_PAGES-1:0]  op_on,             // operation command on
    input  wire logic [NUM_PAGES-1:0]  ramping,           // soft start in progress
    input  wire logic [NUM_PAGES-1:0]  other_shutdown,    // other fault shut rail
    input  wire logic [NUM_PAGES*16-1:0] vout_mv,         // output voltage, 1 mV
    input  wire logic [NUM_PAGES*16-1:0] iout_da,         // summed current, 0.1 A
    output logic      [NUM_PAGES-1:0]  output_enable,     // rail power enable
    output logic                       alert_line_n       // alert, active low
);
    // ==========================================================
    // command decode
    wire hit_uv_thr  = (cmd_code == CMD_UV_THRESHOLD);
    wire hit_uv_resp = (cmd_code == CMD_UV_RESPONSE);
    wire hit_oc_thr  = (cmd_code == CMD_OC_THRESHOLD);
    wire hit_oc_resp = (cmd_code == CMD_OC_RESPONSE);
    wire hit_status  = (cmd_code == CMD_FAULT_STATUS);
    wire code_known  = hit_uv_thr || hit_uv_resp || hit_oc_thr || hit_oc_resp || hit_status;
    // an unknown code is answered but never touches state
    wire wr_cmd      = cmd_valid && cmd_write;
    wire rd_cmd      = cmd_valid && !cmd_write;
    wire wr_uv_thr   = wr_cmd && hit_uv_thr;
    wire wr_uv_resp  = wr_cmd && hit_uv_resp;
    wire wr_oc_thr   = wr_cmd && hit_oc_thr;
    wire wr_oc_resp  = wr_cmd && hit_oc_resp;
    wire wr_status   = wr_cmd && hit_status;

    // ==========================================================
    // pin synchronisers
    logic [NUM_PAGES-1:0] ctrl_meta_r;
    logic [NUM_PAGES-1:0] ctrl_sync_r;
    logic                 bias_meta_r;
    logic                 bias_sync_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_meta_r <= '0;
            ctrl_sync_r <= '0;
            bias_meta_r <= 1'b0;
            bias_sync_r <= 1'b0;
        end else begin
            ctrl_meta_r <= ctrl_pin;
            ctrl_sync_r <= ctrl_meta_r;
            bias_meta_r <= bias_ok_pin;
            bias_sync_r <= bias_meta_r;
        end
    end

    // ==========================================================
    // rail enable qualifiers
    // a lost bias or a commanded off stops any retry
    wire [NUM_PAGES-1:0] rail_enabled = ctrl_sync_r & op_on & {NUM_PAGES{bias_sync_r}};

    // ==========================================================
    // per page registers and responders
    logic [7:0]           uv_resp_r [NUM_PAGES];
    logic [7:0]           oc_resp_r [NUM_PAGES];
    logic [15:0]          uv_thr_r  [NUM_PAGES];
    logic [15:0]          oc_thr_r  [NUM_PAGES];
    logic [1:0]           status_r  [NUM_PAGES];
    logic [NUM_PAGES-1:0] flag_any;

    genvar p;
    generate
        for (p = 0; p < NUM_PAGES; p++) begin : g_page
            rail_if rif ();
            wire        sel        = (cmd_page == 1'(p));
            wire        we_uv_resp = wr_uv_resp && sel;
            wire        we_oc_resp = wr_oc_resp && sel;
            wire        we_uv_thr  = wr_uv_thr && sel;
            wire        we_oc_thr  = wr_oc_thr && sel;
            wire        uv_clr     = wr_status && sel && cmd_wdata[STATUS_UV_BIT];
            wire        oc_clr     = wr_status && sel && cmd_wdata[STATUS_OC_BIT];
            logic [1:0] status_nxt;

            assign rif.uv_resp        = uv_resp_r[p];
            assign rif.oc_resp        = oc_resp_r[p];
            assign rif.uv_thr         = uv_thr_r[p];
            assign rif.oc_thr         = oc_thr_r[p];
            assign rif.enabled        = rail_enabled[p];
            assign rif.ramping        = ramping[p];
            assign rif.other_shutdown = other_shutdown[p];
            assign rif.vout_mv        = vout_mv[p*16 +: 16];
            assign rif.iout_da        = iout_da[p*16 +: 16];
            assign output_enable[p]   = rif.out_en;
            assign flag_any[p]        = |status_r[p];

            // write one to clear; a fault in the same cycle keeps its flag set
            always_comb begin
                status_nxt = status_r[p];
                if (uv_clr) begin
                    status_nxt[STATUS_UV_BIT] = 1'b0;
                end
                if (oc_clr) begin
                    status_nxt[STATUS_OC_BIT] = 1'b0;
                end
                if (rif.uv_event) begin
                    status_nxt[STATUS_UV_BIT] = 1'b1;
                end
                if (rif.oc_event) begin
                    status_nxt[STATUS_OC_BIT] = 1'b1;
                end
            end

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    uv_resp_r[p] <= UV_RESP_RST;
                end else if (we_uv_resp) begin
                    uv_resp_r[p] <= cmd_wdata[7:0];
                end
            end

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    oc_resp_r[p] <= OC_RESP_RST;
                end else if (we_oc_resp) begin
                    oc_resp_r[p] <= cmd_wdata[7:0];
                end
            end

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    uv_thr_r[p] <= UV_THR_RST;
                end else if (we_uv_thr) begin
                    uv_thr_r[p] <= cmd_wdata;
                end
            end

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    oc_thr_r[p] <= OC_THR_RST;
                end else if (we_oc_thr) begin
                    oc_thr_r[p] <= cmd_wdata;
                end
            end

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    status_r[p] <= STATUS_RST;
                end else begin
                    status_r[p] <= status_nxt;
                end
            end

            rail_responder #(
                .STEP_CYCLES (STEP_CYCLES)
            ) u_resp (
                .clock (clock),
                .rst_b (rst_b),
                .rif   (rif)
            );
        end
    endgenerate

    // ==========================================================
    // read mux and answer
    wire [15:0] rd_uv_thr  = uv_thr_r[cmd_page];
    wire [15:0] rd_uv_resp = {8'h00, uv_resp_r[cmd_page]};
    wire [15:0] rd_oc_thr  = oc_thr_r[cmd_page];
    wire [15:0] rd_oc_resp = {8'h00, oc_resp_r[cmd_page]};
    wire [15:0] rd_status  = {14'h0, status_r[cmd_page]};
    // an unknown code selects nothing and reads back zero
    wire [15:0] rd_mux     = ({16{hit_uv_thr}}  & rd_uv_thr)
                           | ({16{hit_uv_resp}} & rd_uv_resp)
                           | ({16{hit_oc_thr}}  & rd_oc_thr)
                           | ({16{hit_oc_resp}} & rd_oc_resp)
                           | ({16{hit_status}}  & rd_status);

    wire        ack_nxt   = cmd_valid && code_known;
    wire        nak_nxt   = cmd_valid && !code_known;
    // the line follows the flags one cycle later
    wire        alert_nxt = ~(|flag_any);
    logic       alert_n_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ack   <= 1'b0;
            cmd_nak   <= 1'b0;
            cmd_rdata <= 16'h0000;
            alert_n_r <= 1'b1;
        end else begin
            cmd_ack   <= ack_nxt;
            cmd_nak   <= nak_nxt;
            if (rd_cmd) begin
                cmd_rdata <= rd_mux;
            end
            alert_n_r <= alert_nxt;
        end
    end

    assign alert_line_n = alert_n_r;
endmodule // uv_fault_response_oc_limit
`default_nettype wire

// [bench/uv_oc_checker_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module uv_oc_checker
    import uv_oc_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = 4
) (
    input wire logic                   clock,          // clock
    input wire logic                   rst_b,          // reset, active low
    input wire logic                   cmd_valid,      // strobe
    input wire logic                   cmd_write,      // direction
    input wire logic                   cmd_page,       // rail
    input wire logic [7:0]             cmd_code,       // command
    input wire logic [15:0]            cmd_wdata,      // write data
    input wire logic                   cmd_ack,        // accepted
    input wire logic                   cmd_nak,        // refused
    input wire logic [15:0]            cmd_rdata,      // read data
    input wire logic [NUM_PAGES-1:0]   ctrl_pin,       // enable pins
    input wire logic                   bias_ok_pin,    // bias good
    input wire logic [NUM_PAGES-1:0]   op_on,          // operation on
    input wire logic [NUM_PAGES-1:0]   ramping,        // soft start
    input wire logic [NUM_PAGES-1:0]   other_shutdown, // other fault
    input wire logic [NUM_PAGES*16-1:0] vout_mv,       // voltages
    input wire logic [NUM_PAGES*16-1:0] iout_da,       // currents
    input wire logic [NUM_PAGES-1:0]   output_enable,  // rail enable
    input wire logic                   alert_line_n    // alert
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire known = cmd_code inside {CMD_UV_THRESHOLD, CMD_UV_RESPONSE, CMD_OC_THRESHOLD,
                                  CMD_OC_RESPONSE, CMD_FAULT_STATUS};
    // ==========================================================
    // shadow of the page 0 current limit, written at the same edge as the design
    logic [15:0] oc_thr_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            oc_thr_r <= OC_THR_RST;
        else if (cmd_valid && cmd_write && !cmd_page && cmd_code == CMD_OC_THRESHOLD)
            oc_thr_r <= cmd_wdata;
    end
    chk_ack_known: assert property (cmd_valid && known |=> cmd_ack && !cmd_nak)
        else $error("known code not acked");
    chk_nak_unknown: assert property (cmd_valid && !known |=> cmd_nak && !cmd_ack)
        else $error("unknown code not refused");
    chk_quiet_bus: assert property (!cmd_valid |=> !cmd_ack && !cmd_nak)
        else $error("answer without request");
    chk_rdata_hold: assert property (!(cmd_valid && !cmd_write) |=> $stable(cmd_rdata))
        else $error("read data moved without read");
    chk_byte_upper: assert property (cmd_valid && !cmd_write && cmd_code == CMD_UV_RESPONSE
        |=> cmd_rdata[15:8] == 8'h00)
        else $error("byte register upper bits set");
    chk_oe_start: assert property ($rose(output_enable[0]) |-> $past(op_on[0]))
        else $error("rail started while commanded off");
    chk_oe_cmd_off: assert property (!op_on[0] |=> !output_enable[0])
        else $error("rail on while commanded off");
    chk_oc_alert: assert property (iout_da[15:0] > oc_thr_r |-> ##2 !alert_line_n)
        else $error("overcurrent not alerted");
    cover property (!alert_line_n);
    cover property ($fell(output_enable[0]));
    cover property (cmd_valid && !known);
endmodule // uv_oc_checker
bind uv_fault_response_oc_limit uv_oc_checker #(.STEP_CYCLES(STEP_CYCLES)) u_uv_oc_checker (.*);
`default_nettype wire

// [bench/cmd_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cmd_host (
    input  wire logic        clock,     // clock
    output logic             cmd_valid, // strobe
    output logic             cmd_write, // direction
    output logic             cmd_page,  // rail
    output logic [7:0]       cmd_code,  // command
    output logic [15:0]      cmd_wdata, // write data
    input  wire logic        cmd_ack,   // accepted
    input  wire logic        cmd_nak,   // refused
    input  wire logic [15:0] cmd_rdata  // read data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_page = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d,
                        output logic [1:0] rsp, output logic [15:0] q);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_page <= p;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        // stale data is scrambled so nothing can lean on it
        cmd_wdata <= ~d;
        #1;
        rsp = {cmd_ack, cmd_nak};
        q = cmd_rdata;
    endtask
endmodule // cmd_host
`default_nettype wire

// [bench/uv_fault_response_oc_limit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module uv_fault_response_oc_limit_bench;
    import uv_oc_pkg::*;
    localparam int unsigned STEP = 4;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        cmd_valid, cmd_write, cmd_page, cmd_ack, cmd_nak, bias_ok_pin, alert_line_n;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata;
    logic [1:0]  ctrl_pin, op_on, ramping, other_shutdown, output_enable;
    logic [31:0] vout_mv, iout_da, r;
    logic [31:0] seed = 32'h03ca59fe;
    int          mismatches = 0;
    int          num_checks = 0;
    always #2.5 clock = ~clock;
    uv_fault_response_oc_limit #(.STEP_CYCLES(STEP)) u_uv_fault_response_oc_limit (.*);
    cmd_host u_cmd_host (.*);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int exp_wait(input logic [2:0] code);
        return code * STEP + 1;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic op(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d,
                      input logic [1:0] er, input logic [15:0] ed, input string n);
        logic [1:0]  rsp;
        logic [15:0] q;
        u_cmd_host.xfer(w, p, c, d, rsp, q);
        chk({n, " rsp"}, {14'h0, er}, {14'h0, rsp});
        if (!w)
            chk(n, ed, q);
    endtask
    task automatic wait_oe(input logic v, input int lim, output int n);
        n = 0;
        while (output_enable[0] !== v) begin
            @(posedge clock);
            #1;
            n++;
            if (n > lim) begin
                chk("oe wait", {15'h0, v}, {15'h0, output_enable[0]});
                complete_run();
            end
        end
    endtask
    // ==========================================================
    // one undervoltage event on rail 0 under a given response byte
    task automatic trip(input logic [7:0] resp);
        int n;
        op(1'b1, 1'b0, CMD_UV_RESPONSE, {8'h00, resp}, 2'b10, 16'h0, "uv_resp wr");
        @(posedge clock);
        op_on[0] <= 1'b1;
        ctrl_pin[0] <= 1'b1;
        wait_oe(1'b1, 20, n);
        @(posedge clock);
        ramping[0] <= 1'b1;
        vout_mv[15:0] <= 16'd500;
        repeat (8) @(posedge clock);
        #1 chk("ramp_mask", 16'h1, {15'h0, output_enable[0]});
        @(posedge clock);
        ramping[0] <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("uv_alert", 16'h0, {15'h0, alert_line_n});
        chk("uv_out", {15'h0, resp[7:6] != 2'b10}, {15'h0, output_enable[0]});
        @(posedge clock);
        vout_mv[15:0] <= 16'd1500;
        if (resp[7:3] == 5'h17) begin
            wait_oe(1'b1, 100, n);
            // n starts counting three edges after the trip edge
            chk("retry_gap", 16'(exp_wait(resp[2:0])), 16'(n + 3));
        end else if (resp[7:6] == 2'b10) begin
            repeat (40) @(posedge clock);
            #1 chk("latched", 16'h0, {15'h0, output_enable[0]});
            op_on[0] <= 1'b0;
            repeat (3) @(posedge clock);
            op_on[0] <= 1'b1;
            wait_oe(1'b1, 20, n);
        end
        op(1'b0, 1'b0, CMD_FAULT_STATUS, 16'h0, 2'b10, 16'h0001, "uv_flag");
        op(1'b1, 1'b0, CMD_FAULT_STATUS, 16'h0001, 2'b10, 16'h0, "clear");
        repeat (3) @(posedge clock);
        #1 chk("alert_clear", 16'h1, {15'h0, alert_line_n});
        $display("test uv response %h done", resp);
    endtask
    initial begin
        ctrl_pin = 2'h0;
        bias_ok_pin = 1'b1;
        op_on = 2'h0;
        ramping = 2'h0;
        other_shutdown = 2'h0;
        vout_mv = {2{16'd1500}};
        iout_da = 32'h0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        op(1'b0, 1'b0, CMD_UV_RESPONSE, 16'h0, 2'b10, 16'h0084, "uv_resp rst");
        op(1'b0, 1'b1, CMD_UV_RESPONSE, 16'h0, 2'b10, 16'h0084, "uv_resp rst1");
        op(1'b0, 1'b1, CMD_OC_THRESHOLD, 16'h0, 2'b10, 16'h012c, "oc_thr rst");
        op(1'b0, 1'b0, CMD_OC_RESPONSE, 16'h0, 2'b10, {8'h00, OC_RESP_RST}, "oc_resp rst");
        op(1'b0, 1'b0, 8'h30, 16'h0, 2'b01, 16'h0, "unknown");
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            op(1'b1, r[16], CMD_OC_THRESHOLD, r[15:0], 2'b10, 16'h0, "oc_thr wr");
            op(1'b0, r[16], CMD_OC_THRESHOLD, 16'h0, 2'b10, r[15:0], "oc_thr");
            // only the low byte of the write word lands in a byte register
            op(1'b1, r[17], CMD_UV_RESPONSE, r[31:16], 2'b10, 16'h0, "uv_resp wr");
            op(1'b0, r[17], CMD_UV_RESPONSE, 16'h0, 2'b10, {8'h00, r[23:16]}, "uv_resp");
        end
        $display("test random access done");
        op(1'b1, 1'b0, CMD_OC_THRESHOLD, 16'hffff, 2'b10, 16'h0, "oc_thr wr");
        op(1'b1, 1'b0, CMD_UV_THRESHOLD, 16'd1000, 2'b10, 16'h0, "uv_thr wr");
        trip(8'h84);
        trip(8'h00);
        trip(8'h40);
        trip(8'hc4);
        trip(8'h8c);
        trip(8'hb9);
        trip(8'hbf);
        op(1'b1, 1'b0, CMD_OC_THRESHOLD, 16'h012c, 2'b10, 16'h0, "oc_thr wr");
        @(posedge clock);
        iout_da[15:0] <= 16'h012c;
        repeat (4) @(posedge clock);
        #1 chk("oc_equal", 16'h1, {15'h0, alert_line_n});
        iout_da[15:0] <= 16'h012d;
        repeat (3) @(posedge clock);
        #1 chk("oc_alert", 16'h0, {15'h0, alert_line_n});
        chk("oc_shut", 16'h0, {15'h0, output_enable[0]});
        op(1'b0, 1'b0, CMD_FAULT_STATUS, 16'h0, 2'b10, 16'h0002, "oc_flag");
        $display("test overcurrent done");
        complete_run();
    end
endmodule // uv_fault_response_oc_limit_bench
`default_nettype wire
